// ---- logic/bpc_backlight_cfg.sv ----
// backlight configuration block: apb registers, 32-byte configuration
// store with sram front end, shadow copy and nonvolatile array, dimming
// frequency decode and thermal derating of the dimming duty.
// assumes duty_in, temp_code, strings_used and chip_enable come from logic
// on clk; ext_dim_pin is an asynchronous pin and is synchronised here.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// RULE_01 - stagger off, mode 0: frequency from the 3-bit rate field only
// RULE_02 - stagger off, mode 1: each of 32 codes has its own frequency
// RULE_03 - stagger mode 0: shift = rate frequency / 1,2,4,8; output = shift/N
// RULE_04 - stagger mode 1: output = mode 1 frequency; shift = output x N
// RULE_05 - above limit, duty drops 4% of full scale per degree
// RULE_06 - thermal derating runs whenever the chip is enabled
// RULE_07 - 11-bit temperature in high and low registers; read high first
// RULE_08 - threshold select 00..11 gives 100, 110, 120, 130 degrees
// RULE_09 - store holds 32 bytes with a host-accessible sram front end
// RULE_10 - store access only while backlight is off and dim pin low
// RULE_11 - ready status bit tells whether the store may be accessed
// RULE_12 - coefficient and spare bytes have no shadow; writes act at once
// RULE_13 - shadowed bytes act only after update+reload set then cleared
// RULE_14 - after reset the nonvolatile array loads sram and shadow
// RULE_15 - writing reload to 1 loads sram and shadow from nonvolatile
// RULE_16 - erase bit written 1 then 0 erases the nonvolatile array
// RULE_17 - program bit written 1 then 0 copies sram into nonvolatile
// RULE_18 - staggered dimming on by default, off when its store bit is 1
// RULE_19 - at top stagger frequency boost stays constant, not per phase
// RULE_20 - ready reads low while any store operation is running
// RULE_21 - store writes ignored and reads zero while dimming is active
module bpc_backlight_cfg (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // apb slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [`BPC_ADDR_W-1:0]   paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // chip inputs
   input  wire logic                     chip_enable,
   input  wire logic                     ext_dim_pin,
   input  wire logic [`BPC_DUTY_W-1:0]   duty_in,
   input  wire logic [`BPC_TEMP_W-1:0]   temp_code,
   input  wire logic [2:0]               strings_used,
   // dimming outputs
   output logic      [`BPC_DUTY_W-1:0]   duty_out,
   output logic      [`BPC_FREQ_W-1:0]   out_freq_hz,
   output logic      [`BPC_FREQ_W-1:0]   shift_freq_hz,
   output logic                          staggered_string_dimming,
   output logic                          constant_boost,
   // store status and unshadowed curve coefficients
   output logic                          backlight_on,
   output logic                          store_ready,
   output logic      [127:0]             curve_coef
);

   // ****************************************************************
   // state, nonvolatile array and decoder
   // ****************************************************************
   bpc_pkg::bpc_state_t    s;
   bpc_pkg::bpc_state_t    next_s;
   bpc_pkg::bpc_freq_cfg_t freq_cfg;
   bpc_pkg::bpc_freq_t     freq_dec;
   logic [7:0]             nvm [`BPC_STORE_BYTES];
   logic                   nvm_we;
   logic [7:0]             nvm_wd;

   // the array keeps its contents through reset; it starts erased
   initial begin
      for (int i = 0; i < `BPC_STORE_BYTES; i++) begin
         nvm[i] = `BPC_ERASED_BYTE;
      end
   end

   always_ff @(posedge clk) begin
      if (nvm_we) begin
         nvm[s.idx] <= nvm_wd;                      // RULE_16 RULE_17
      end
   end

   // shadowed configuration feeds the decoder, not the live sram
   assign freq_cfg.code        = s.shadow[`BPC_CFG_FREQ_IDX][4:0]; // RULE_13
   assign freq_cfg.mode        = s.shadow[`BPC_CFG_FREQ_IDX][`BPC_MODE_BIT];
   assign freq_cfg.stagger_off =
      s.shadow[`BPC_CFG_FREQ_IDX][`BPC_STAGOFF_BIT];               // RULE_18
   assign freq_cfg.strings     = strings_used;

   bpc_freq_decode u_freq_decode (
      .cfg  (freq_cfg),
      .freq (freq_dec)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic                   active;
      logic                   busy;
      logic                   ready;
      logic                   setup;
      logic                   access;
      logic                   in_store;
      logic [4:0]             widx;
      logic [`BPC_CTRL_W-1:0] new_ctrl;
      logic [7:0]             lim;
      logic [7:0]             tint;
      logic [31:0]            cut;
      logic [31:0]            rd;
      logic                   err;
      active   = 1'b0;
      busy     = 1'b0;
      ready    = 1'b0;
      setup    = 1'b0;
      access   = 1'b0;
      in_store = 1'b0;
      widx     = 5'h00;
      new_ctrl = s.ctrl;
      lim      = 8'h00;
      tint     = 8'h00;
      cut      = 32'h0;
      rd       = 32'h0;
      err      = 1'b0;
      next_s   = s;
      nvm_we   = 1'b0;
      nvm_wd   = `BPC_ERASED_BYTE;

      // external dim pin: two flops before anything reads it
      next_s.dim_s1 = ext_dim_pin;
      next_s.dim_s2 = s.dim_s1;

      active = s.ctrl[`BPC_CTRL_BL_BIT] | s.dim_s2;             // RULE_10
      busy   = (s.op != bpc_pkg::ST_IDLE);
      ready  = ~active & ~busy;                                 // RULE_11 RULE_20

      setup    = psel & ~penable;
      access   = psel & penable;
      in_store = (paddr[`BPC_ADDR_W-1:7] == `BPC_STORE_WIN_HI) &&
                 (paddr[1:0] == 2'h0);
      widx     = paddr[6:2];

      // ************************************************************
      // read data and error, captured in the setup cycle
      // ************************************************************
      next_s.pslverr = 1'b0;
      if (setup) begin
         case (paddr)
            `BPC_CTRL_OFS:       rd = {27'h0, s.ctrl};
            `BPC_STAT_OFS:       rd = {27'h0, s.derating,
                                       s.freq.staggered, s.freq.const_boost,
                                       busy, ready};            // RULE_11
            `BPC_TEMP_HI_OFS: begin
               rd = {24'h0, temp_code[`BPC_TEMP_W-1:`BPC_TEMP_FRAC]};
               // freeze the low part so a following low read matches
               next_s.temp_lo = temp_code[`BPC_TEMP_FRAC-1:0];  // RULE_07
            end
            `BPC_TEMP_LO_OFS:    rd = {29'h0, s.temp_lo};       // RULE_07
            `BPC_OUT_FREQ_OFS:   rd = {14'h0, s.freq.out_hz};
            `BPC_SHIFT_FREQ_OFS: rd = {14'h0, s.freq.shift_hz};
            `BPC_DUTY_OFS:       rd = {20'h0, s.duty};
            default: begin
               if (in_store) begin
                  rd = ready ? {24'h0, s.sram[widx]} : 32'h0;   // RULE_21
               end else begin
                  err = 1'b1;
               end
            end
         endcase
         next_s.prdata  = rd;
         next_s.pslverr = err;
      end

      // ************************************************************
      // writes, taken at the access edge
      // ************************************************************
      if (access && pwrite) begin
         if (paddr == `BPC_CTRL_OFS) begin
            new_ctrl    = pwdata[`BPC_CTRL_W-1:0];
            next_s.ctrl = new_ctrl;
         end else if (in_store && ready) begin
            // unshadowed bytes drive curve_coef straight from sram
            next_s.sram[widx] = pwdata[7:0];                    // RULE_09 RULE_12
         end
      end

      // ************************************************************
      // store commands; edges of the control bits start a sequence
      // ************************************************************
      if (!busy) begin
         if (new_ctrl[`BPC_CTRL_UPDATE_BIT] &&
             new_ctrl[`BPC_CTRL_RELOAD_BIT]) begin
            next_s.upd_armed = 1'b1;                            // RULE_13
         end else if (s.upd_armed && !new_ctrl[`BPC_CTRL_UPDATE_BIT] &&
                      !new_ctrl[`BPC_CTRL_RELOAD_BIT]) begin
            next_s.upd_armed = 1'b0;
            next_s.op        = bpc_pkg::ST_UPDATE;              // RULE_13
            next_s.idx       = 5'h00;
         end else if (!s.upd_armed && new_ctrl[`BPC_CTRL_RELOAD_BIT] &&
                      !s.ctrl[`BPC_CTRL_RELOAD_BIT]) begin
            next_s.op  = bpc_pkg::ST_LOAD;                      // RULE_15
            next_s.idx = 5'h00;
         end else if (s.ctrl[`BPC_CTRL_ERASE_BIT] &&
                      !new_ctrl[`BPC_CTRL_ERASE_BIT]) begin
            next_s.op  = bpc_pkg::ST_ERASE;                     // RULE_16
            next_s.idx = 5'h00;
         end else if (s.ctrl[`BPC_CTRL_PROG_BIT] &&
                      !new_ctrl[`BPC_CTRL_PROG_BIT]) begin
            next_s.op  = bpc_pkg::ST_PROGRAM;                   // RULE_17
            next_s.idx = 5'h00;
         end
      end

      // ************************************************************
      // store sequencer: one byte per clock, 32 clocks per operation
      // ************************************************************
      case (s.op)
         bpc_pkg::ST_IDLE: begin
         end
         bpc_pkg::ST_LOAD: begin
            next_s.sram[s.idx]   = nvm[s.idx];                  // RULE_14 RULE_15
            next_s.shadow[s.idx] = nvm[s.idx];                  // RULE_14 RULE_15
         end
         bpc_pkg::ST_UPDATE: begin
            next_s.shadow[s.idx] = s.sram[s.idx];               // RULE_13
         end
         bpc_pkg::ST_ERASE: begin
            nvm_we = 1'b1;                                      // RULE_16
            nvm_wd = `BPC_ERASED_BYTE;
         end
         bpc_pkg::ST_PROGRAM: begin
            nvm_we = 1'b1;                                      // RULE_17
            nvm_wd = s.sram[s.idx];
         end
         default: begin
            next_s.op = bpc_pkg::ST_IDLE;
         end
      endcase
      if (busy) begin
         next_s.idx = s.idx + 5'h01;
         if (s.idx == 5'h1f) begin
            next_s.op = bpc_pkg::ST_IDLE;                       // RULE_20
         end
      end

      // ************************************************************
      // thermal derating of the dimming duty
      // ************************************************************
      lim = `BPC_LIM_BASE_C +
            8'(`BPC_LIM_STEP_C * {6'h00,
               s.shadow[`BPC_CFG_TEMP_IDX][1:0]});              // RULE_08
      tint = temp_code[`BPC_TEMP_W-1:`BPC_TEMP_FRAC];
      next_s.derating = chip_enable && (tint >= lim);           // RULE_06
      if (next_s.derating) begin
         // integer division keeps 4% steps; 25 degrees cuts full scale
         cut = ({24'h0, 8'(tint - lim)} * `BPC_DUTY_FS) /
               `BPC_DERATE_SPAN_C;                              // RULE_05
         next_s.duty = (cut >= {20'h0, duty_in}) ? '0 :
                       `BPC_DUTY_W'({20'h0, duty_in} - cut);    // RULE_05
      end else begin
         next_s.duty = duty_in;
      end

      next_s.freq = freq_dec;
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s      <= '0;
         s.ctrl <= `BPC_CTRL_RST;
         s.op   <= bpc_pkg::ST_LOAD;                            // RULE_14
      end else begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // zero-wait slave: every access completes in its first access cycle
   assign pready                   = 1'b1;
   assign prdata                   = s.prdata;
   assign pslverr                  = s.pslverr;
   assign duty_out                 = s.duty;
   assign out_freq_hz              = s.freq.out_hz;
   assign shift_freq_hz            = s.freq.shift_hz;
   assign staggered_string_dimming = s.freq.staggered;
   assign constant_boost           = s.freq.const_boost;
   assign backlight_on             = s.ctrl[`BPC_CTRL_BL_BIT];
   assign store_ready              = ~s.ctrl[`BPC_CTRL_BL_BIT] & ~s.dim_s2 &
                                     (s.op == bpc_pkg::ST_IDLE);
   assign curve_coef               = s.sram[`BPC_COEF_LAST:0];  // RULE_12

endmodule : bpc_backlight_cfg

`default_nettype wire

// ---- logic/bpc_freq_decode.sv ----
// dimming frequency decoder: 5-bit code, mode and stagger setting in,
// per-string output and shift frequency out; purely combinational, the
// caller registers the result
`timescale 1ns/1ns
`default_nettype none

module bpc_freq_decode (
   // configuration
   input  wire bpc_pkg::bpc_freq_cfg_t cfg,
   // decoded frequencies
   output bpc_pkg::bpc_freq_t          freq
);

   // ****************************************************************
   // per-code table: {mode 0 shift frequency, mode 1 output frequency}
   // ****************************************************************
   function automatic logic [2*`BPC_FREQ_W-1:0] code_tbl(
      input logic [4:0] c);
      case (c)
         5'h00: code_tbl = {18'd992,   18'd229};
         5'h01: code_tbl = {18'd496,   18'd305};
         5'h02: code_tbl = {18'd248,   18'd381};
         5'h03: code_tbl = {18'd124,   18'd458};
         5'h04: code_tbl = {18'd1526,  18'd534};
         5'h05: code_tbl = {18'd763,   18'd610};
         5'h06: code_tbl = {18'd382,   18'd687};
         5'h07: code_tbl = {18'd191,   18'd763};
         5'h08: code_tbl = {18'd1983,  18'd839};
         5'h09: code_tbl = {18'd993,   18'd916};
         5'h0a: code_tbl = {18'd496,   18'd992};
         5'h0b: code_tbl = {18'd248,   18'd1068};
         5'h0c: code_tbl = {18'd2441,  18'd1144};
         5'h0d: code_tbl = {18'd1221,  18'd1221};
         5'h0e: code_tbl = {18'd610,   18'd1297};
         5'h0f: code_tbl = {18'd305,   18'd1373};
         5'h10: code_tbl = {18'd2974,  18'd1450};
         5'h11: code_tbl = {18'd1487,  18'd1526};
         5'h12: code_tbl = {18'd744,   18'd1602};
         5'h13: code_tbl = {18'd372,   18'd1678};
         5'h14: code_tbl = {18'd3965,  18'd1755};
         5'h15: code_tbl = {18'd1983,  18'd1831};
         5'h16: code_tbl = {18'd991,   18'd1908};
         5'h17: code_tbl = {18'd496,   18'd1983};
         5'h18: code_tbl = {18'd4883,  18'd2060};
         5'h19: code_tbl = {18'd2441,  18'd2671};
         5'h1a: code_tbl = {18'd1221,  18'd3203};
         5'h1b: code_tbl = {18'd610,   18'd3737};
         5'h1c: code_tbl = {18'd19531, 18'd4270};
         5'h1d: code_tbl = {18'd9766,  18'd4808};
         5'h1e: code_tbl = {18'd4883,  18'd9766};
         default: code_tbl = {18'd2441, 18'd19531};
      endcase
   endfunction : code_tbl

   // ****************************************************************
   // mode and stagger selection
   // ****************************************************************
   always_comb begin
      logic [`BPC_FREQ_W-1:0] rate_hz;
      logic [`BPC_FREQ_W-1:0] shift0_hz;
      logic [`BPC_FREQ_W-1:0] mode1_hz;
      logic [`BPC_FREQ_W-1:0] n;
      rate_hz   = code_tbl({cfg.code[4:2], 2'h0})[2*`BPC_FREQ_W-1:`BPC_FREQ_W];
      shift0_hz = code_tbl(cfg.code)[2*`BPC_FREQ_W-1:`BPC_FREQ_W];
      mode1_hz  = code_tbl(cfg.code)[`BPC_FREQ_W-1:0];
      // zero strings would divide by zero; treat as one string
      n = (cfg.strings == 3'h0) ? 18'h00001 : {15'h0000, cfg.strings};
      freq.staggered = ~cfg.stagger_off;                      // RULE_18
      if (cfg.stagger_off) begin
         freq.out_hz   = cfg.mode ? mode1_hz : rate_hz;       // RULE_01 RULE_02
         freq.shift_hz = freq.out_hz;
      end else if (!cfg.mode) begin
         freq.shift_hz = shift0_hz;                           // RULE_03
         freq.out_hz   = shift0_hz / n;                       // RULE_03
      end else begin
         freq.out_hz   = mode1_hz;                            // RULE_04
         freq.shift_hz = 18'(mode1_hz * n);                   // RULE_04
      end
      // per-phase boost tracking has no time at the top stagger rate
      freq.const_boost = ~cfg.stagger_off &
         ((cfg.mode ? mode1_hz : shift0_hz) == `BPC_FREQ_MAX_HZ); // RULE_19
   end

endmodule : bpc_freq_decode

`default_nettype wire

// ---- pkg/bpc_pkg.sv ----
// types shared by the backlight configuration block and its decoder;
// expects bpc_regs.svh on the include path
`include "bpc_regs.svh"

package bpc_pkg;

   // ****************************************************************
   // store operation sequencer
   // ****************************************************************
   typedef enum logic [4:0] {
      ST_IDLE    = 5'h01,
      ST_LOAD    = 5'h02,
      ST_UPDATE  = 5'h04,
      ST_ERASE   = 5'h08,
      ST_PROGRAM = 5'h10
   } bpc_op_t;

   // ****************************************************************
   // frequency decoder carriers
   // ****************************************************************
   typedef struct packed {
      logic [4:0] code;
      logic       mode;
      logic       stagger_off;
      logic [2:0] strings;
   } bpc_freq_cfg_t;

   typedef struct packed {
      logic [`BPC_FREQ_W-1:0] out_hz;
      logic [`BPC_FREQ_W-1:0] shift_hz;
      logic                   staggered;
      logic                   const_boost;
   } bpc_freq_t;

   // ****************************************************************
   // whole state of the top module
   // ****************************************************************
   typedef struct packed {
      logic [`BPC_STORE_BYTES-1:0][7:0] sram;
      logic [`BPC_STORE_BYTES-1:0][7:0] shadow;
      bpc_op_t                          op;
      logic [4:0]                       idx;
      logic [`BPC_CTRL_W-1:0]           ctrl;
      logic                             upd_armed;
      logic                             dim_s1;
      logic                             dim_s2;
      logic [`BPC_TEMP_FRAC-1:0]        temp_lo;
      logic [31:0]                      prdata;
      logic                             pslverr;
      logic [`BPC_DUTY_W-1:0]           duty;
      logic                             derating;
      bpc_freq_t                        freq;
   } bpc_state_t;

endpackage : bpc_pkg

// ---- pkg/bpc_regs.svh ----
// register offsets, field positions, reset values and fixed figures of the
// backlight configuration block; assumes a 12-bit byte address on the apb
`ifndef BPC_REGS_SVH
`define BPC_REGS_SVH

// ****************************************************************
// apb register map (byte addresses, one aligned word each)
// ****************************************************************
`define BPC_ADDR_W          12
`define BPC_CTRL_OFS        12'h000
`define BPC_STAT_OFS        12'h004
`define BPC_TEMP_HI_OFS     12'h008
`define BPC_TEMP_LO_OFS     12'h00c
`define BPC_OUT_FREQ_OFS    12'h010
`define BPC_SHIFT_FREQ_OFS  12'h014
`define BPC_DUTY_OFS        12'h018
`define BPC_STORE_WIN_HI    5'h02
`define BPC_STORE_LOC_BASE  8'ha0

// ****************************************************************
// control and status fields
// ****************************************************************
`define BPC_CTRL_W          5
`define BPC_CTRL_BL_BIT     0
`define BPC_CTRL_RELOAD_BIT 1
`define BPC_CTRL_UPDATE_BIT 2
`define BPC_CTRL_ERASE_BIT  3
`define BPC_CTRL_PROG_BIT   4
`define BPC_CTRL_RST        5'h00
`define BPC_STAT_READY_BIT  0
`define BPC_STAT_BUSY_BIT   1
`define BPC_STAT_CBOOST_BIT 2
`define BPC_STAT_STAG_BIT   3
`define BPC_STAT_DERATE_BIT 4

// ****************************************************************
// configuration store layout (byte index = location - a0h)
// ****************************************************************
`define BPC_STORE_BYTES     32
`define BPC_COEF_LAST       5'h0f
`define BPC_SPARE_FIRST     5'h14
`define BPC_SPARE_LAST      5'h1b
`define BPC_CFG_FREQ_IDX    5'h10
`define BPC_CFG_TEMP_IDX    5'h11
`define BPC_MODE_BIT        5
`define BPC_STAGOFF_BIT     6
`define BPC_ERASED_BYTE     8'h00

// ****************************************************************
// thermal derating and frequency figures
// ****************************************************************
`define BPC_TEMP_W          11
`define BPC_TEMP_FRAC       3
`define BPC_LIM_BASE_C      8'h64
`define BPC_LIM_STEP_C      8'h0a
`define BPC_DERATE_SPAN_C   32'h19
`define BPC_DUTY_W          12
`define BPC_DUTY_FS         32'hfff
`define BPC_FREQ_W          18
`define BPC_FREQ_MAX_HZ     18'h04c4b

`endif

// ---- test/bpc_apb_host.sv ----
// apb master standing for the host controller
// drives after rising edges; slave answers with pready
`timescale 1ns/1ns
`default_nettype none
module bpc_apb_host (
   // bus
   input  wire logic        clk, pready, pslverr,
   input  wire logic [31:0] prdata,
   output logic             psel, penable, pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata
);
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      // released data no longer shows the last value
      {psel, penable, pwdata} <= {2'b00, ~d};
   endtask : xfer
   // command bit set then cleared
   task automatic pulse(input logic [31:0] bits);
      logic [31:0] q;
      logic        e;
      xfer(1'b1, 12'h000, bits, q, e);
      xfer(1'b1, 12'h000, 32'h0, q, e);
   endtask : pulse
endmodule : bpc_apb_host
`default_nettype wire

// ---- test/bpc_assertions.sv ----
// port checks for bpc_backlight_cfg, bound below
// one clock domain, synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module bpc_assertions (
   // clock, reset, bus and chip inputs
   input wire logic        clk, rst_n, psel, penable, pslverr,
   input wire logic        chip_enable,
   input wire logic [11:0] duty_in,
   input wire logic [10:0] temp_code,
   // observed outputs
   input wire logic [11:0] duty_out,
   input wire logic [17:0] out_freq_hz,
   input wire logic        staggered_string_dimming, constant_boost,
   input wire logic        backlight_on, store_ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   err_in_access_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access");
   store_locked_a: assert property (backlight_on |-> !store_ready)
      else $error("ready while backlight on");
   load_busy_a: assert property ($rose(rst_n) |-> !store_ready [*8])
      else $error("ready during load");
   cool_pass_a: assert property ((!chip_enable || temp_code[10:3] < 8'h64)
      |=> duty_out == $past(duty_in))
      else $error("duty cut below limit");
   hot_zero_a: assert property (chip_enable && temp_code[10:3] >= 8'h9b
      |=> duty_out == 12'h000)
      else $error("duty not zero when hot");
   never_more_a: assert property (duty_out <= $past(duty_in))
      else $error("duty raised");
   boost_stag_a: assert property (constant_boost
      |-> staggered_string_dimming)
      else $error("constant boost unstaggered");
   freq_cap_a: assert property (out_freq_hz <= 18'h04c4b)
      else $error("frequency over top");
   cover property ($rose(store_ready));
   cover property (pslverr);
   cover property (duty_out == 12'h000 && duty_in != 12'h000);
endmodule : bpc_assertions
bind bpc_backlight_cfg bpc_assertions chk (.clk(clk), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pslverr(pslverr),
   .chip_enable(chip_enable), .duty_in(duty_in), .temp_code(temp_code),
   .duty_out(duty_out), .out_freq_hz(out_freq_hz),
   .staggered_string_dimming(staggered_string_dimming),
   .constant_boost(constant_boost), .backlight_on(backlight_on),
   .store_ready(store_ready));
`default_nettype wire

// ---- test/bpc_backlight_cfg_tb.sv ----
// self-checking bench for bpc_backlight_cfg
// nvm starts erased; checker binds itself
`timescale 1ns/1ns
`default_nettype none
module bpc_backlight_cfg_tb;
   logic        clk, rst_n, ce, dimp, psel, penable, pwrite, pready, pslverr;
   logic        stg, cb, blon, rdy, e;
   logic [2:0]  nstr;
   logic [10:0] temp;
   logic [11:0] duty, paddr, dout;
   logic [17:0] fo, fs;
   logic [31:0] pwdata, prdata, q;
   logic [127:0] coef;
   int          bad_count, num_checks;
   // {chip_enable, whole degrees, duty in, duty out}
   logic [35:0] rows [5] = '{36'h1_63_fff_fff, 36'h1_64_fff_fff,
      36'h1_69_fff_ccc, 36'h0_7d_fff_fff, 36'h1_6e_100_000};
   bpc_apb_host host (.clk(clk), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata));
   bpc_backlight_cfg dut (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chip_enable(ce), .ext_dim_pin(dimp), .duty_in(duty),
      .temp_code(temp), .strings_used(nstr), .duty_out(dout),
      .out_freq_hz(fo), .shift_freq_hz(fs), .staggered_string_dimming(stg),
      .constant_boost(cb), .backlight_on(blon), .store_ready(rdy),
      .curve_coef(coef));
   task automatic chk(input string n, input logic [31:0] s, x);
      num_checks++;
      if (s !== x) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   task automatic wait_rdy();
      repeat (100) begin
         @(negedge clk);
         if (rdy === 1'b1) break;
      end
      chk("ready", rdy, 1);
   endtask : wait_rdy
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
   initial begin
      {rst_n, ce, dimp, duty, temp, nstr} = {3'b000, 12'hfff, 11'h0, 3'h2};
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("load", rdy, 0);
      wait_rdy();
      chk("stagger", stg, 1);
      chk("out", fo, 32'h1f0);
      chk("shift", fs, 32'h3e0);
      foreach (rows[i]) begin
         @(posedge clk);
         {ce, temp, duty} <= {rows[i][32:24], 3'h0, rows[i][23:12]};
         repeat (2) @(negedge clk);
         chk("duty", dout, rows[i][11:0]);
      end
      host.xfer(1, 12'h140, 32'h7f, q, e);
      host.xfer(1, 12'h144, 32'h3, q, e);
      chk("held", fo, 32'h1f0);
      host.pulse(32'h6);
      wait_rdy();
      {temp, duty} <= {11'h418, 12'hfff};
      repeat (2) @(negedge clk);
      chk("mode1", fo, 32'h4c4b);
      chk("unstag", stg, 0);
      chk("lim130", dout, 32'hf5c);
      host.xfer(1, 12'h100, 32'ha5, q, e);
      host.xfer(1, 12'h000, 32'h1, q, e);
      chk("coef", coef[7:0], 32'ha5);
      host.xfer(1, 12'h100, 32'h11, q, e);
      host.xfer(0, 12'h100, 0, q, e);
      chk("locked", q, 0);
      host.xfer(1, 12'h000, 32'h0, q, e);
      dimp <= 1'b1;
      repeat (3) @(negedge clk);
      chk("pin", rdy, 0);
      dimp <= 1'b0;
      wait_rdy();
      host.pulse(32'h8);
      host.xfer(0, 12'h004, 0, q, e);
      chk("busy", q[1:0], 2'b10);
      wait_rdy();
      host.pulse(32'h10);
      wait_rdy();
      host.xfer(1, 12'h100, 32'h0, q, e);
      host.pulse(32'h2);
      wait_rdy();
      host.xfer(0, 12'h100, 0, q, e);
      chk("nvm", q, 32'ha5);
      temp <= 11'h2d5;
      host.xfer(0, 12'h008, 0, q, e);
      chk("temp_hi", q, 32'h5a);
      host.xfer(0, 12'h00c, 0, q, e);
      chk("temp_lo", q, 32'h5);
      host.xfer(0, 12'h0fc, 0, q, e);
      chk("unmapped", e, 1);
      print_verdict();
   end
endmodule : bpc_backlight_cfg_tb
`default_nettype wire
